// *** spd_pkg.sv ***
// package of constants for the pulse reference decoder
//
// Summary of operation
// [RQ1] match while speed difference below width setting
// [RQ2] match output closed on match, else open
// [RQ3] match output only in speed control
// [RQ4] method code 1 is position, latched at restart
// [RQ5] form 0: direction high forward, low reverse
// [RQ6] form 5: direction and pulse polarity inverted
// [RQ7] form 1: separate forward/reverse pulses, idle low
// [RQ8] form 6: separate pulses inverted, idle high
// [RQ9] forms 2,3,4: quadrature x1, x2, x4
// [RQ10] B leading A forward, lagging reverse
// [RQ11] host keeps quadrature at most 1 Mpps
// [RQ12] host keeps pulses at most 4 Mpps
// [RQ13] filter code chosen at restart sets filter
// [RQ14] conducting open collector reads as high
// [RQ15] accumulate forward counts, subtract reverse counts
package spd_pkg;
	// ------------------------------------------------------------
	// APB register map
	// ------------------------------------------------------------
	localparam logic [7:0] SPD_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] SPD_ADDR_WIDTH  = 8'h04;
	localparam logic [7:0] SPD_ADDR_REFSPD = 8'h08;
	localparam logic [7:0] SPD_ADDR_ACTSPD = 8'h0c;
	localparam logic [7:0] SPD_ADDR_POS    = 8'h10;
	localparam logic [7:0] SPD_ADDR_STATUS = 8'h14;
	// ctrl fields: form [3:0], method [7:4], filter [11:8]
	localparam int SPD_FORM_LSB   = 0;
	localparam int SPD_METHOD_LSB = 4;
	localparam int SPD_FILT_LSB   = 8;
	localparam logic [31:0] SPD_CTRL_RST  = 32'h0000_0000;
	localparam logic [6:0]  SPD_WIDTH_RST = 7'h0a;
	localparam logic [6:0]  SPD_WIDTH_MAX = 7'h64;
	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [3:0] SPD_METHOD_SPEED = 4'h0;
	localparam logic [3:0] SPD_METHOD_POS   = 4'h1;
	localparam logic [3:0] SPD_FORM_SIGN_P = 4'h0;
	localparam logic [3:0] SPD_FORM_CWCCW_P = 4'h1;
	localparam logic [3:0] SPD_FORM_QX1    = 4'h2;
	localparam logic [3:0] SPD_FORM_QX2    = 4'h3;
	localparam logic [3:0] SPD_FORM_QX4    = 4'h4;
	localparam logic [3:0] SPD_FORM_SIGN_N = 4'h5;
	localparam logic [3:0] SPD_FORM_CWCCW_N = 4'h6;
	localparam logic [3:0] SPD_FILT_LD1 = 4'h0;
	localparam logic [3:0] SPD_FILT_OC  = 4'h1;
	localparam logic [3:0] SPD_FILT_LD2 = 4'h2;
	// ------------------------------------------------------------
	// filter timing at 200 MHz
	// ------------------------------------------------------------
	localparam int SPD_CLK_MHZ     = 200;
	localparam int SPD_T_LD1_NS    = 250;
	localparam int SPD_T_OC_NS     = 1250;
	localparam int SPD_T_LD2_NS    = 60;
	localparam int SPD_N_LD1 = SPD_T_LD1_NS * SPD_CLK_MHZ / 1000;
	localparam int SPD_N_OC  = SPD_T_OC_NS * SPD_CLK_MHZ / 1000;
	localparam int SPD_N_LD2 = SPD_T_LD2_NS * SPD_CLK_MHZ / 1000;
	localparam int SPD_FCNT_W = 9;
	localparam int SPD_POS_W  = 32;
	localparam int SPD_SPD_W  = 16;
endpackage : spd_pkg

// *** spd_filt_if.sv ***
// interface between the decoder top and the input filter
`timescale 1ns/1ps
interface spd_filt_if;
	logic       in_a;    // synchronised pin a
	logic       in_b;    // synchronised pin b
	logic [8:0] limit;   // stable cycles needed minus one
	logic       out_a;   // filtered a
	logic       out_b;   // filtered b
	modport top (output in_a, output in_b, output limit,
		input out_a, input out_b);
	modport filt (input in_a, input in_b, input limit,
		output out_a, output out_b);
endinterface : spd_filt_if

// *** spd_filter.sv ***
// glitch filter for the two reference inputs
`timescale 1ns/1ps
module spd_filter
	import spd_pkg::*;
(
	input wire logic clk,    // 200 MHz clock
	input wire logic rst_n,  // async reset, active low
	spd_filt_if.filt f       // filter link
);
	logic [1:0] raw;
	logic [1:0] out_q;
	assign raw = {f.in_b, f.in_a};
	assign f.out_a = out_q[0];
	assign f.out_b = out_q[1];

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			logic [SPD_FCNT_W-1:0] cnt_q;
			// output follows input after it has differed from it for limit + 1 cycles
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cnt_q    <= '0;
					out_q[i] <= 1'b0;
				end else if (raw[i] == out_q[i]) begin
					cnt_q <= '0;
				end else if (cnt_q >= f.limit) begin
					cnt_q    <= '0;
					out_q[i] <= raw[i]; // RQ13
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	endgenerate
endmodule : spd_filter

// *** spd_decoder.sv ***
// pulse reference decoder and speed match output with apb registers
`timescale 1ns/1ps
module spd_decoder
	import spd_pkg::*;
(
	input  wire logic        clk,             // 200 MHz clock
	input  wire logic        rst_n,           // async reset, active low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb enable
	input  wire logic        pwrite,          // apb direction
	input  wire logic [7:0]  paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error
	input  wire logic        ref_in_a,        // pulse / cw / phase a pin
	input  wire logic        ref_in_b,        // sign / ccw / phase b pin
	output logic             speed_match_out, // high = closed (on)
	output logic             pos_mode         // position control active
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0]            ctrl_q;
	logic [6:0]             speed_match_width;
	logic [SPD_SPD_W-1:0]   ref_speed_q;
	logic [SPD_SPD_W-1:0]   act_speed_q;
	logic [SPD_POS_W-1:0]   pos_q;
	logic [3:0]             ref_pulse_form_sel;
	logic [3:0]             control_method_sel;
	logic [3:0]             filt_sel_q;
	logic                   cfg_done_q;
	logic                   wr_en;
	logic                   wr_ctrl;
	logic                   wr_width;
	logic                   wr_refspd;
	logic                   wr_actspd;
	logic                   rd_en;
	logic                   addr_ok;
	logic [6:0]             wdata_w;

	// a write lands only at the edge that completes the transfer
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite;
	assign wdata_w = pwdata[6:0];

	always_comb begin
		unique case (paddr)
			SPD_ADDR_CTRL, SPD_ADDR_WIDTH, SPD_ADDR_REFSPD,
			SPD_ADDR_ACTSPD, SPD_ADDR_POS, SPD_ADDR_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// apb write side
	// ------------------------------------------------------------
	assign wr_ctrl   = wr_en && (paddr == SPD_ADDR_CTRL);
	assign wr_width  = wr_en && (paddr == SPD_ADDR_WIDTH);
	assign wr_refspd = wr_en && (paddr == SPD_ADDR_REFSPD);
	assign wr_actspd = wr_en && (paddr == SPD_ADDR_ACTSPD);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= SPD_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata;
		end
	end

	// width takes effect at once; the whole word is compared so that
	// a large value clamps instead of wrapping in the low bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_match_width <= SPD_WIDTH_RST;
		end else if (wr_width) begin
			if (pwdata > {25'h0, SPD_WIDTH_MAX}) begin
				speed_match_width <= SPD_WIDTH_MAX; // RQ1
			end else begin
				speed_match_width <= wdata_w;       // RQ1
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_speed_q <= '0;
		end else if (wr_refspd) begin
			ref_speed_q <= pwdata[SPD_SPD_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_speed_q <= '0;
		end else if (wr_actspd) begin
			act_speed_q <= pwdata[SPD_SPD_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// restart-time latch of method, form and filter
	// ------------------------------------------------------------
	// the control word is sampled once after reset release; later
	// writes reach only ctrl_q, which the next reset clears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_done_q         <= 1'b0;
			ref_pulse_form_sel <= SPD_FORM_SIGN_P;
			control_method_sel <= SPD_METHOD_SPEED;
			filt_sel_q         <= SPD_FILT_LD1;
		end else if (!cfg_done_q && wr_ctrl) begin
			cfg_done_q         <= 1'b1;
			ref_pulse_form_sel <= pwdata[SPD_FORM_LSB +: 4];   // RQ4
			control_method_sel <= pwdata[SPD_METHOD_LSB +: 4]; // RQ4
			filt_sel_q         <= pwdata[SPD_FILT_LSB +: 4];   // RQ13
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_mode <= 1'b0;
		end else begin
			pos_mode <= (control_method_sel == SPD_METHOD_POS); // RQ4
		end
	end

	// ------------------------------------------------------------
	// apb read side
	// ------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
		end
	end

	logic [31:0] rd_mux_w;
	always_comb begin
		unique case (paddr)
			SPD_ADDR_CTRL:   rd_mux_w = ctrl_q;
			SPD_ADDR_WIDTH:  rd_mux_w = {25'h0, speed_match_width};
			SPD_ADDR_REFSPD: rd_mux_w = {16'h0, ref_speed_q};
			SPD_ADDR_ACTSPD: rd_mux_w = {16'h0, act_speed_q};
			SPD_ADDR_POS:    rd_mux_w = pos_q;
			SPD_ADDR_STATUS: rd_mux_w = {18'h0, filt_sel_q,
				control_method_sel, ref_pulse_form_sel,
				pos_mode, speed_match_out};
			default:         rd_mux_w = '0;
		endcase
	end

	// read data are captured in the first access cycle and stand
	// until the next read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (rd_en && !pready) begin
			prdata <= rd_mux_w;
		end
	end

	// ------------------------------------------------------------
	// speed coincidence
	// ------------------------------------------------------------
	logic [SPD_SPD_W:0] diff_w;
	always_comb begin
		diff_w = {1'b0, ref_speed_q} - {1'b0, act_speed_q};
		if (diff_w[SPD_SPD_W]) begin
			diff_w = {1'b0, act_speed_q} - {1'b0, ref_speed_q};
		end
	end

	logic in_speed_w;
	logic coincide_w;
	assign in_speed_w = (control_method_sel == SPD_METHOD_SPEED);
	assign coincide_w = (diff_w < {10'h0, speed_match_width});

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_match_out <= 1'b0;
		end else begin
			// open whenever not coinciding or not in speed control
			speed_match_out <= in_speed_w && coincide_w; // RQ1 RQ2 RQ3
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers, three stages
	// ------------------------------------------------------------
	logic [1:0] pin_raw;
	logic [1:0] pin_stab;
	assign pin_raw = {ref_in_b, ref_in_a};

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_pin
			logic [2:0] sync_q;
			logic       stab_q;
			// open-collector: conducting transistor arrives as high level
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					sync_q <= '0;
				end else begin
					sync_q <= {sync_q[1:0], pin_raw[p]}; // RQ14
				end
			end

			// a change counts once the second and third stage agree
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stab_q <= 1'b0;
				end else if (sync_q[1] == sync_q[2]) begin
					stab_q <= sync_q[2];
				end
			end
			assign pin_stab[p] = stab_q;
		end
	endgenerate

	// ------------------------------------------------------------
	// input filter
	// ------------------------------------------------------------
	spd_filt_if fl ();
	logic [SPD_FCNT_W-1:0] lim_w;
	always_comb begin
		unique case (filt_sel_q)
			SPD_FILT_OC:  lim_w = SPD_FCNT_W'(SPD_N_OC);
			SPD_FILT_LD2: lim_w = SPD_FCNT_W'(SPD_N_LD2);
			default:      lim_w = SPD_FCNT_W'(SPD_N_LD1);
		endcase
	end
	assign fl.in_a  = pin_stab[0];
	assign fl.in_b  = pin_stab[1];
	assign fl.limit = lim_w; // RQ13

	spd_filter i_spd_filter (
		.clk   (clk),
		.rst_n (rst_n),
		.f     (fl.filt)
	);

	// ------------------------------------------------------------
	// pulse decoding
	// ------------------------------------------------------------
	logic [1:0] filt_w;
	logic [1:0] rise_w;
	logic [1:0] fall_w;
	assign filt_w = {fl.out_b, fl.out_a};

	generate
		for (p = 0; p < 2; p++) begin : g_edge
			logic last_q;
			// previous filtered level, for edge detection
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					last_q <= 1'b0;
				end else begin
					last_q <= filt_w[p];
				end
			end
			assign rise_w[p] = filt_w[p] && !last_q;
			assign fall_w[p] = !filt_w[p] && last_q;
		end
	endgenerate

	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic b_fall;
	logic a_edge;
	logic b_edge;
	logic fwd;
	logic rev;
	assign a_rise = rise_w[0];
	assign a_fall = fall_w[0];
	assign b_rise = rise_w[1];
	assign b_fall = fall_w[1];
	assign a_edge = a_rise || a_fall;
	assign b_edge = b_rise || b_fall;

	always_comb begin
		fwd = 1'b0;
		rev = 1'b0;
		unique case (ref_pulse_form_sel)
			SPD_FORM_SIGN_P: begin
				fwd = a_rise && fl.out_b;   // RQ5
				rev = a_rise && !fl.out_b;  // RQ5
			end
			SPD_FORM_SIGN_N: begin
				fwd = a_fall && !fl.out_b;  // RQ6
				rev = a_fall && fl.out_b;   // RQ6
			end
			SPD_FORM_CWCCW_P: begin
				fwd = b_rise;               // RQ7
				rev = a_rise;               // RQ7
			end
			SPD_FORM_CWCCW_N: begin
				fwd = b_fall;               // RQ8
				rev = a_fall;               // RQ8
			end
			SPD_FORM_QX1: begin
				// one count per cycle, on rising a
				fwd = a_rise && fl.out_b;   // RQ9 RQ10
				rev = a_rise && !fl.out_b;  // RQ9 RQ10
			end
			SPD_FORM_QX2: begin
				fwd = a_edge && (fl.out_a == fl.out_b);  // RQ9 RQ15
				rev = a_edge && (fl.out_a != fl.out_b);  // RQ9 RQ15
			end
			SPD_FORM_QX4: begin
				// b leading a: a follows b, same level after an a edge
				fwd = (a_edge && (fl.out_a == fl.out_b)) ||
					(b_edge && (fl.out_a != fl.out_b));  // RQ10 RQ15
				rev = (a_edge && (fl.out_a != fl.out_b)) ||
					(b_edge && (fl.out_a == fl.out_b));  // RQ10 RQ15
			end
			default: ;
		endcase
	end

	// ------------------------------------------------------------
	// position reference accumulator
	// ------------------------------------------------------------
	// counting follows the method latched at restart, not ctrl_q
	logic pos_cnt_en;
	assign pos_cnt_en = (control_method_sel == SPD_METHOD_POS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_q <= '0;
		end else if (pos_cnt_en) begin
			if (fwd && !rev) begin
				pos_q <= pos_q + 1'b1; // RQ15
			end else if (rev && !fwd) begin
				pos_q <= pos_q - 1'b1; // RQ15
			end
		end
	end
endmodule : spd_decoder

// *** spd_decoder_props.sv ***
// assertion checker for the pulse reference decoder ports
`timescale 1ns/1ps
module spd_decoder_props
	import spd_pkg::*;
(
	input wire logic        clk,             // 200 MHz clock
	input wire logic        rst_n,           // async reset, active low
	input wire logic        psel,            // apb select
	input wire logic        penable,         // apb enable
	input wire logic        pwrite,          // apb direction
	input wire logic [7:0]  paddr,           // apb byte address
	input wire logic [31:0] pwdata,          // apb write data
	input wire logic [31:0] prdata,          // apb read data
	input wire logic        pready,          // apb ready
	input wire logic        pslverr,         // apb error
	input wire logic        ref_in_a,        // reference pin a
	input wire logic        ref_in_b,        // reference pin b
	input wire logic        speed_match_out, // speed match
	input wire logic        pos_mode         // position control
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// bus timing
	// ------------------------------------------------------------
	a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_one: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_map: assert property (pready && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > 8'h14)) else $error("slave error wrong");
	a_rd_unmapped: assert property (pready && !pwrite && paddr > 8'h14
		|-> prdata == 32'h0) else $error("unmapped read not zero");
	// ------------------------------------------------------------
	// speed match and mode
	// ------------------------------------------------------------
	a_width_clamp: assert property (pready && !pwrite &&
		paddr == SPD_ADDR_WIDTH |-> prdata <= 32'h64)
		else $error("width above limit");
	a_width_zero: assert property (pready && pwrite &&
		paddr == SPD_ADDR_WIDTH && pwdata[6:0] == 7'h0
		|-> ##2 !speed_match_out) else $error("match with zero width");
	a_match_speed: assert property (pos_mode && $past(pos_mode)
		|-> !speed_match_out) else $error("match in position mode");
	a_mode_hold: assert property (pos_mode |=> pos_mode)
		else $error("mode changed without restart");
	a_reset_quiet: assert property ($rose(rst_n)
		|-> !pready && !speed_match_out && !pos_mode)
		else $error("output active after reset");
endmodule : spd_decoder_props
bind spd_decoder spd_decoder_props i_spd_decoder_props (.clk, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.ref_in_a, .ref_in_b, .speed_match_out, .pos_mode);

// *** spd_host_model.sv ***
// host controller model driving the pulse train reference pins
`timescale 1ns/1ps
module spd_host_model (
	input wire logic clk, // bench clock
	output logic     a,   // pulse / cw / phase a
	output logic     b    // sign / ccw / phase b
);
	// cycles per level: slower than the open-collector limit
	localparam int HOLD = 300;
	logic [3:0] form = 4'h0;
	logic       n    = 1'b0;
	initial begin
		a = 1'b0;
		b = 1'b0;
	end
	task automatic lvl(input logic va, input logic vb);
		@(posedge clk);
		a <= va;
		b <= vb;
		repeat (HOLD) @(posedge clk);
	endtask : lvl
	task automatic idle(input logic [3:0] f);
		form = f;
		n = (f == 4'h5 || f == 4'h6);
		lvl(n, n);
	endtask : idle
	task automatic step(input logic fwd);
		case (form)
		4'h0, 4'h5: begin
			lvl(n, fwd ^ n);
			lvl(~n, fwd ^ n);
			lvl(n, fwd ^ n);
		end
		4'h1, 4'h6: begin
			lvl(n ^ ~fwd, n ^ fwd);
			lvl(n, n);
		end
		default: begin
			lvl(~fwd, fwd);
			lvl(1'b1, 1'b1);
			lvl(fwd, ~fwd);
			lvl(1'b0, 1'b0);
		end
		endcase
	endtask : step
endmodule : spd_host_model

// *** spd_decoder_tb.sv ***
// testbench for the pulse reference decoder
`timescale 1ns/1ps
module spd_decoder_tb
	import spd_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ref_a;
	logic        ref_b;
	logic        match;
	logic        pos_mode;
	logic [31:0] rdata;
	logic        serr;
	int          err_count = 0;
	int          total_checks = 0;
	int          mult[7] = '{1, 1, 1, 2, 4, 1, 1};
	initial begin
		forever #2.5 clk = ~clk;
	end
	spd_decoder i_spd_decoder (.clk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .ref_in_a(ref_a),
		.ref_in_b(ref_b), .speed_match_out(match), .pos_mode);
	spd_host_model i_spd_host_model (.clk, .a(ref_a), .b(ref_b));
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
		apb(1'b0, ad, 32'h0);
		chk("read data", e, rdata);
	endtask : rdc
	task automatic pin(input logic e);
		repeat (3) @(posedge clk);
		chk("match out", {31'h0, e}, {31'h0, match});
	endtask : pin
	task automatic restart;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : restart
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		summarize();
	end
	initial begin
		restart();
		rdc(SPD_ADDR_CTRL, SPD_CTRL_RST);
		rdc(SPD_ADDR_WIDTH, 32'h0a);
		apb(1'b1, SPD_ADDR_REFSPD, 32'h7d0);
		apb(1'b1, SPD_ADDR_ACTSPD, 32'h7c7);
		pin(1'b1);
		apb(1'b1, SPD_ADDR_ACTSPD, 32'h7c6);
		pin(1'b0);
		apb(1'b1, SPD_ADDR_ACTSPD, 32'h7d9);
		pin(1'b1);
		apb(1'b1, SPD_ADDR_ACTSPD, 32'h7da);
		pin(1'b0);
		apb(1'b1, SPD_ADDR_WIDTH, 32'h0);
		apb(1'b1, SPD_ADDR_ACTSPD, 32'h7d0);
		pin(1'b0);
		apb(1'b1, SPD_ADDR_WIDTH, 32'hc8);
		rdc(SPD_ADDR_WIDTH, 32'h64);
		pin(1'b1);
		apb(1'b1, 8'h20, 32'h1);
		chk("slverr", 32'h1, {31'h0, serr});
		rdc(8'h20, 32'h0);
		apb(1'b1, SPD_ADDR_POS, 32'h55);
		rdc(SPD_ADDR_POS, 32'h0);
		for (int f = 0; f < 7; f++) begin
			restart();
			i_spd_host_model.idle(4'(f));
			apb(1'b1, SPD_ADDR_CTRL,
				{20'h0, 4'(f % 3), SPD_METHOD_POS, 4'(f)});
			apb(1'b1, SPD_ADDR_CTRL, 32'h0);
			chk("pos mode", 32'h1, {31'h0, pos_mode});
			pin(1'b0);
			repeat (3) i_spd_host_model.step(1'b1);
			rdc(SPD_ADDR_POS, 32'(3 * mult[f]));
			i_spd_host_model.step(1'b0);
			rdc(SPD_ADDR_POS, 32'(2 * mult[f]));
		end
		summarize();
	end
endmodule : spd_decoder_tb
